//--- laser_fire_interlock_control_tb.sv
// self-checking bench for the fire interlock top
`timescale 1ns/1ps
`default_nettype none
module laser_fire_interlock_control_tb;
    localparam int LCK = 200, FIR = 20, DEB = 4, PER = 100;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] v; logic [1:0] rs;} lfi_row_s;
    logic aclk, aresetn, clk_en, shot_button, mode_10hz, enable_button, overload_monitor_input;
    logic ref_10hz, sync_delay_generator_gate, rear_error_led, front_error_led, irq;
    logic front_armed_led, rear_armed_led, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int pulses, width, fails, check_count, cyc, p0, n;
    lfi_row_s rows [13] = '{'{1'b0, 8'h04, 32'h0, 2'h0}, '{1'b0, 8'h0c, 32'h0, 2'h0},
        '{1'b0, 8'h00, 32'h0, 2'h0}, '{1'b0, 8'h08, 32'h0, 2'h0}, '{1'b1, 8'h04, 32'hff, 2'h0},
        '{1'b0, 8'h04, 32'h7, 2'h0}, '{1'b1, 8'h04, 32'h2, 2'h0}, '{1'b0, 8'h04, 32'h2, 2'h0},
        '{1'b0, 8'h10, 32'h0, 2'h2}, '{1'b1, 8'h10, 32'hff, 2'h2}, '{1'b1, 8'h0c, 32'h1, 2'h0},
        '{1'b0, 8'h0c, 32'h1, 2'h0}, '{1'b1, 8'h0c, 32'h0, 2'h0}};
    lfi_top #(.LOCKOUT_CYC(LCK), .FIRE_CYC(FIR), .DEBOUNCE_CYC(DEB)) uut (.aclk, .aresetn,
        .clk_en, .shot_button, .mode_10hz, .enable_button, .overload_monitor_input, .ref_10hz,
        .sync_delay_generator_gate, .rear_error_led, .front_error_led, .front_armed_led,
        .rear_armed_led, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    lfi_sdg_model #(.PER(PER)) sdg (.aclk, .gate(sync_delay_generator_gate), .ref_10hz,
        .pulses, .width);
    // clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge aclk);
    endtask
    // bus write: address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        bit ad, wd, bd;
        ad = 0;
        wd = 0;
        bd = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bd) begin
            @(posedge aclk);
            if (ad && wd && s_axi_bvalid) begin
                bd = 1;
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
            if (!ad && s_axi_awready) begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wd && s_axi_wready) begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        @(posedge aclk);
    endtask
    // bus read
    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        bit ad, bd;
        ad = 0;
        bd = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!bd) begin
            @(posedge aclk);
            if (ad && s_axi_rvalid) begin
                bd = 1;
                v = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
            if (!ad && s_axi_arready) begin
                ad = 1;
                s_axi_arvalid <= 1'b0;
            end
        end
        @(posedge aclk);
    endtask
    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fails++;
            close_out();
        end
    end
    // main sequence
    initial begin
        {aresetn, shot_button, mode_10hz, enable_button, overload_monitor_input} = 5'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        clk_en = 1'b1;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        {fails, check_count} = 0;
        cycles(16);
        chk("reset lamps", 32'h0, {front_armed_led, rear_armed_led, sync_delay_generator_gate});
        aresetn <= 1'b1;
        cycles(4);
        chk("armed lamps", 32'h3, {front_armed_led, rear_armed_led});
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axw(rows[i].a, rows[i].v, r);
            end else begin
                axr(rows[i].a, d, r);
                chk("rdata", rows[i].v, d);
            end
            chk("resp", 32'(rows[i].rs), 32'(r));
        end
        // a bounce shorter than the debounce time, then a real press
        p0 = pulses;
        shot_button <= 1'b1;
        cycles(2);
        shot_button <= 1'b0;
        cycles(2 * PER);
        chk("bounce shots", 32'h0, pulses - p0);
        shot_button <= 1'b1;
        cycles(DEB + 8);
        shot_button <= 1'b0;
        cycles(2 * PER);
        chk("single shots", 32'h1, pulses - p0);
        chk("pulse width", FIR, width);
        cycles(PER);
        chk("single shots", 32'h1, pulses - p0);
        // interrupt raised, masked, cleared
        chk("irq", 32'h1, irq);
        axr(8'h00, d, r);
        chk("status", 32'h2, d);
        axw(8'h04, 32'h0, r);
        chk("irq masked", 32'h0, irq);
        axw(8'h00, 32'h2, r);
        axw(8'h04, 32'h2, r);
        chk("irq cleared", 32'h0, irq);
        // free running mode
        mode_10hz <= 1'b1;
        cycles(5);
        @(posedge ref_10hz);
        p0 = pulses;
        cycles(3 * PER);
        chk("rate shots", 32'h3, pulses - p0);
        chk("pulse width", FIR, width);
        // enable button held
        enable_button <= 1'b1;
        cycles(6);
        chk("inhibit lamps", 32'h1, {front_armed_led, rear_armed_led, front_error_led});
        p0 = pulses;
        cycles(3 * PER);
        chk("inhibit shots", 32'h0, pulses - p0);
        enable_button <= 1'b0;
        cycles(PER);
        axw(8'h00, 32'h7, r);
        // overload and lockout
        overload_monitor_input <= 1'b1;
        cycles(4);
        chk("rear error", 32'h1, rear_error_led);
        overload_monitor_input <= 1'b0;
        cycles(1);
        p0 = pulses;
        n = 0;
        while (front_error_led && n < 2 * LCK) begin
            n++;
            @(posedge aclk);
        end
        chk("lockout", 32'h1, 32'(n >= LCK - 5 && n <= LCK));
        chk("blocked shots", 32'h0, pulses - p0);
        chk("rear error", 32'h0, rear_error_led);
        axr(8'h00, d, r);
        chk("status", 32'h7, d);
        // software inhibit keeps the gate shut
        axw(8'h0c, 32'h1, r);
        p0 = pulses;
        cycles(2 * PER);
        chk("inhibit reg shots", 32'h0, pulses - p0);
        axw(8'h0c, 32'h0, r);
        // clock enable low freezes a pulse in progress
        while (sync_delay_generator_gate) begin
            @(posedge aclk);
        end
        while (!sync_delay_generator_gate) begin
            @(posedge aclk);
        end
        clk_en <= 1'b0;
        cycles(3 * FIR);
        chk("frozen gate", 32'h1, sync_delay_generator_gate);
        clk_en <= 1'b1;
        cycles(FIR + 5);
        chk("frozen width", 32'(4 * FIR), width);
        close_out();
    end
endmodule
`default_nettype wire

//--- lfi_debounce.sv
// synchroniser and debouncer for one operator input
`timescale 1ns/1ps
`default_nettype none
module lfi_debounce #(
    parameter logic [27:0] LEN = 28'h0000001
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic raw,
    output logic clean
);
    logic s1_q;
    logic s2_q;
    logic [27:0] cnt_q;
    logic clean_q;

    // two-stage synchroniser, first stage only feeds the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else if (ce) begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    // accept a new level only once it has held for len cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 28'h0000000;
            clean_q <= 1'b0;
        end else if (ce) begin
            if (s2_q == clean_q) begin
                cnt_q <= 28'h0000000;
            end else if (cnt_q >= LEN - 28'h0000001) begin
                clean_q <= s2_q;
                cnt_q <= 28'h0000000;
            end else begin
                cnt_q <= cnt_q + 28'h0000001;
            end
        end
    end

    assign clean = clean_q;
endmodule
`default_nettype wire

//--- lfi_pkg.sv
// package of constants for the laser fire interlock control block
package lfi_pkg;
    // clock rate
    localparam int unsigned CLK_HZ = 125000000;
    // times in their own units
    localparam int unsigned LOCKOUT_MS = 1500;
    localparam int unsigned FIRE_MS = 55;
    localparam int unsigned DEBOUNCE_MS = 5;
    // derived cycle counts
    localparam int unsigned LOCKOUT_CYC = (CLK_HZ / 1000) * LOCKOUT_MS;
    localparam int unsigned FIRE_CYC = (CLK_HZ / 1000) * FIRE_MS;
    localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int unsigned CNT_W = 28;
    // register map
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] MASK_OFS = 8'h04;
    localparam logic [7:0] STATE_OFS = 8'h08;
    localparam logic [7:0] CTRL_OFS = 8'h0c;
    // status and mask bit positions
    localparam int unsigned EV_OVERLOAD = 0;
    localparam int unsigned EV_FIRE = 1;
    localparam int unsigned EV_BLOCKED = 2;
    localparam int unsigned EV_W = 3;
    // reset values and bus response codes
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;
    localparam logic CTRL_RST = 1'b0;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

//--- lfi_sdg_model.sv
// model of the delay generator: reference source and gate pulse meter
`timescale 1ns/1ps
`default_nettype none
module lfi_sdg_model #(
    parameter int PER = 100
) (
    input wire logic aclk,
    input wire logic gate,
    output logic ref_10hz,
    output int pulses,
    output int width
);
    int ph_q;
    int run_q;
    // free running reference, high for the first half of each period
    always_ff @(posedge aclk) begin
        ph_q <= (ph_q >= PER - 1) ? 0 : ph_q + 1;
    end
    always_comb ref_10hz = (ph_q < PER / 2);
    // count gate pulses and keep the length of the last one
    always_ff @(posedge aclk) begin
        run_q <= gate ? run_q + 1 : 0;
        if (gate && run_q == 0) begin
            pulses <= pulses + 1;
        end
        if (!gate && run_q != 0) begin
            width <= run_q;
        end
    end
endmodule
`default_nettype wire

//--- lfi_timer.sv
// one-shot down counter used for lockout and fire pulse widths
`timescale 1ns/1ps
`default_nettype none
module lfi_timer #(
    parameter logic [27:0] LEN = 28'h0000001
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic fire,
    output logic busy,
    output logic start
);
    logic [27:0] cnt_q;

    // retriggerable count of len cycles from the fire request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 28'h0000000;
        end else if (ce) begin
            if (fire) begin
                cnt_q <= LEN;
            end else if (cnt_q != 28'h0000000) begin
                cnt_q <= cnt_q - 28'h0000001;
            end
        end
    end

    assign busy = (cnt_q != 28'h0000000);
    assign start = ce & fire;
endmodule
`default_nettype wire

//--- lfi_top.sv
// fire control and overload lockout with an axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
module lfi_top #(
    parameter int unsigned LOCKOUT_CYC = lfi_pkg::LOCKOUT_CYC,
    parameter int unsigned FIRE_CYC = lfi_pkg::FIRE_CYC,
    parameter int unsigned DEBOUNCE_CYC = lfi_pkg::DEBOUNCE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic shot_button,
    input wire logic mode_10hz,
    input wire logic enable_button,
    input wire logic overload_monitor_input,
    input wire logic ref_10hz,
    output logic sync_delay_generator_gate,
    output logic rear_error_led,
    output logic front_error_led,
    output logic front_armed_led,
    output logic rear_armed_led,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int unsigned EW = lfi_pkg::EV_W;

    logic btn_clean;
    logic btn_prev_q;
    logic [1:0] mode_sync_q;
    logic [1:0] en_sync_q;
    logic [1:0] mon_sync_q;
    logic [1:0] ref_sync_q;
    logic ref_prev_q;
    logic ref_rise;
    logic req_q;
    logic stage_q;
    logic trig;
    logic over;
    logic over_prev_q;
    logic lock_busy;
    logic fire_busy;
    logic fire_start;
    logic enable_held;
    logic gate_q;
    logic rear_err_q;
    logic front_err_q;
    logic armed_q;
    logic sw_inhibit_q;
    logic [EW-1:0] status_q;
    logic [EW-1:0] mask_q;
    logic [EW-1:0] ev;
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_do;
    logic [EW-1:0] w1c;

    // register offset decode shared by the read and write paths
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == lfi_pkg::STATUS_OFS) || (a == lfi_pkg::MASK_OFS) ||
            (a == lfi_pkg::STATE_OFS) || (a == lfi_pkg::CTRL_OFS);
    endfunction

    // button debouncer including its own synchroniser
    lfi_debounce #(.LEN(DEBOUNCE_CYC[27:0])) u_btn (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(clk_en),
        .raw(shot_button),
        .clean(btn_clean)
    );

    // level synchronisers for the remaining inputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_sync_q <= 2'h0;
            en_sync_q <= 2'h0;
            mon_sync_q <= 2'h0;
            ref_sync_q <= 2'h0;
        end else if (clk_en) begin
            mode_sync_q <= {mode_sync_q[0], mode_10hz};
            en_sync_q <= {en_sync_q[0], enable_button};
            mon_sync_q <= {mon_sync_q[0], overload_monitor_input};
            ref_sync_q <= {ref_sync_q[0], ref_10hz};
        end
    end

    // edge history for button, reference and overload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            btn_prev_q <= 1'b0;
            ref_prev_q <= 1'b0;
            over_prev_q <= 1'b0;
        end else if (clk_en) begin
            btn_prev_q <= btn_clean;
            ref_prev_q <= ref_sync_q[1];
            over_prev_q <= over;
        end
    end

    assign ref_rise = ref_sync_q[1] & ~ref_prev_q;
    assign over = mon_sync_q[1];
    assign enable_held = en_sync_q[1];

    // request latch and 10 hz second stage, both cleared on fire start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q <= 1'b0;
            stage_q <= 1'b0;
        end else if (clk_en) begin
            if (fire_start) begin
                req_q <= 1'b0;
                stage_q <= 1'b0;
            end else begin
                if (btn_clean & ~btn_prev_q) begin
                    req_q <= 1'b1;
                end
                if (ref_rise) begin
                    stage_q <= req_q;
                end
            end
        end
    end

    // trigger source per mode switch, new pulse only when idle
    assign trig = mode_sync_q[1] ? ref_rise : stage_q;

    // lockout timer fired on each overload rising edge
    lfi_timer #(.LEN(LOCKOUT_CYC[27:0])) u_lock (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(clk_en),
        .fire(over & ~over_prev_q),
        .busy(lock_busy),
        .start()
    );

    // fire pulse timer
    lfi_timer #(.LEN(FIRE_CYC[27:0])) u_fire (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(clk_en),
        .fire(trig & ~fire_busy),
        .busy(fire_busy),
        .start(fire_start)
    );

    // output gate and panel indicators
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_q <= 1'b0;
            rear_err_q <= 1'b0;
            front_err_q <= 1'b0;
            armed_q <= 1'b0;
        end else if (clk_en) begin
            gate_q <= fire_busy & ~lock_busy & ~enable_held & ~sw_inhibit_q;
            rear_err_q <= over;
            front_err_q <= lock_busy | enable_held;
            armed_q <= ~enable_held;
        end
    end

    assign sync_delay_generator_gate = gate_q;
    assign rear_error_led = rear_err_q;
    assign front_error_led = front_err_q;
    assign front_armed_led = armed_q;
    assign rear_armed_led = armed_q;

    // events: overload, fire pulse start, fire blocked by interlock
    assign ev[lfi_pkg::EV_OVERLOAD] = over & ~over_prev_q;
    assign ev[lfi_pkg::EV_FIRE] = fire_start;
    assign ev[lfi_pkg::EV_BLOCKED] = fire_start & (lock_busy | enable_held);

    // axi write: take address and data in any order, then respond
    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready = ~w_held_q & ~bvalid_q;
    assign wr_do = aw_held_q & w_held_q & ~bvalid_q;
    assign w1c = (wr_do && awaddr_q == lfi_pkg::STATUS_OFS && wstrb_q[0]) ?
        wdata_q[EW-1:0] : {EW{1'b0}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= lfi_pkg::AXI_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= mapped(awaddr_q) ? lfi_pkg::AXI_OKAY : lfi_pkg::AXI_SLVERR;
            end else if (bvalid_q & s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // mask and inhibit control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= lfi_pkg::MASK_RST;
            sw_inhibit_q <= lfi_pkg::CTRL_RST;
        end else if (clk_en && wr_do && wstrb_q[0]) begin
            if (awaddr_q == lfi_pkg::MASK_OFS) begin
                mask_q <= wdata_q[EW-1:0];
            end
            if (awaddr_q == lfi_pkg::CTRL_OFS) begin
                sw_inhibit_q <= wdata_q[0];
            end
        end
    end

    // sticky status, a new event wins over a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= {EW{1'b0}};
        end else if (clk_en) begin
            status_q <= (status_q & ~w1c) | ev;
        end
    end

    assign irq = |(status_q & mask_q);

    // axi read with registered data
    assign s_axi_arready = ~rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= lfi_pkg::AXI_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid & s_axi_arready) begin
                rvalid_q <= 1'b1;
                rresp_q <= mapped({s_axi_araddr[7:2], 2'h0}) ?
                    lfi_pkg::AXI_OKAY : lfi_pkg::AXI_SLVERR;
                unique case ({s_axi_araddr[7:2], 2'h0})
                    lfi_pkg::STATUS_OFS: rdata_q <= {29'h0, status_q};
                    lfi_pkg::MASK_OFS: rdata_q <= {29'h0, mask_q};
                    lfi_pkg::STATE_OFS: rdata_q <= {26'h0, enable_held, over,
                        mode_sync_q[1], gate_q, fire_busy, lock_busy};
                    lfi_pkg::CTRL_OFS: rdata_q <= {31'h0, sw_inhibit_q};
                    default: rdata_q <= 32'h00000000;
                endcase
            end else if (rvalid_q & s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
endmodule
`default_nettype wire

//--- lfi_top_sva.sv
// concurrent checks on the ports of the fire interlock top
`timescale 1ns/1ps
`default_nettype none
module lfi_top_sva #(
    parameter int unsigned LOCKOUT_CYC = 200,
    parameter int unsigned FIRE_CYC = 20,
    parameter int unsigned DEBOUNCE_CYC = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic enable_button,
    input wire logic overload_monitor_input,
    input wire logic sync_delay_generator_gate,
    input wire logic rear_error_led,
    input wire logic front_error_led,
    input wire logic front_armed_led,
    input wire logic rear_armed_led,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    int unsigned run_q;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // enabled cycles the gate has been high so far, frozen cycles do not count
    always_ff @(posedge aclk) begin
        if (!aresetn || !sync_delay_generator_gate) begin
            run_q <= 0;
        end else if (clk_en) begin
            run_q <= run_q + 1;
        end
    end
    ovl_rear_a: assert property (
        $rose(overload_monitor_input) |-> ##[1:4] rear_error_led) else $error("no rear error");
    lock_front_a: assert property (
        $rose(rear_error_led) |-> ##[0:2] front_error_led [*8]) else $error("no lockout");
    lock_gate_a: assert property (
        $past(front_error_led) && front_error_led |-> !sync_delay_generator_gate)
        else $error("gate open in lockout");
    enable_a: assert property (
        enable_button [*5] |-> front_error_led && !front_armed_led && !rear_armed_led
        && !sync_delay_generator_gate) else $error("enable hold ignored");
    armed_a: assert property (
        !enable_button [*5] |-> front_armed_led && rear_armed_led) else $error("armed lamps off");
    pulse_max_a: assert property (
        sync_delay_generator_gate |-> run_q < FIRE_CYC) else $error("fire pulse too long");
    write_resp_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("no write response");
    b_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_resp_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
    r_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule
bind lfi_top lfi_top_sva #(.LOCKOUT_CYC(LOCKOUT_CYC), .FIRE_CYC(FIRE_CYC),
    .DEBOUNCE_CYC(DEBOUNCE_CYC)) chk (.aclk, .aresetn, .clk_en, .enable_button,
    .overload_monitor_input, .sync_delay_generator_gate, .rear_error_led, .front_error_led,
    .front_armed_led, .rear_armed_led, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
